// ### inc/mdrb_pkg.sv
/*
  Shared constants for the multichannel converter register bank: address map,
  field positions, reset values, state type.
  Assumes a 32-bit Avalon-MM master with byte addressing.
*/
package mdrb_pkg;

  localparam int ADDR_W     = 10;
  localparam int CHANNELS   = 32;
  localparam int GROUP_SIZE = 8;
  localparam int GROUPS     = 4;
  localparam int WIDE_W     = 16;
  localparam int NARROW_W   = 14;
  localparam int SHIFT_W    = 14;
  localparam int CONFIG_W   = 3;
  localparam int SELECT_W   = 8;

  // byte address: [9:8] kind, [6:2] channel or global index
  localparam int KIND_LSB = 8;
  localparam int CHAN_LSB = 2;

  localparam logic [1:0] KIND_DATA   = 2'h0;
  localparam logic [1:0] KIND_GAIN   = 2'h1;
  localparam logic [1:0] KIND_TRIM   = 2'h2;
  localparam logic [1:0] KIND_GLOBAL = 2'h3;

  localparam logic [4:0] IDX_SHIFT0     = 5'h00;
  localparam logic [4:0] IDX_SHIFT1     = 5'h01;
  localparam logic [4:0] IDX_CONFIG     = 5'h02;
  localparam logic [4:0] IDX_SELECT0    = 5'h03;
  localparam logic [4:0] IDX_SELECT3    = 5'h06;
  localparam logic [4:0] IDX_SELECT_ALL = 5'h07;

  localparam int CFG_POWER_DOWN_BIT = 0;
  localparam int CFG_THERMAL_BIT    = 1;
  localparam int CFG_INPUT_SEL_BIT  = 2;

  localparam logic [15:0] WIDE_INPUT_RST   = 16'h5554;
  localparam logic [15:0] WIDE_GAIN_RST    = 16'hffff;
  localparam logic [15:0] WIDE_TRIM_RST    = 16'h8000;
  localparam logic [15:0] NARROW_INPUT_RST = 16'h1555;
  localparam logic [15:0] NARROW_GAIN_RST  = 16'h3fff;
  localparam logic [15:0] NARROW_TRIM_RST  = 16'h2000;
  localparam logic [13:0] SHIFT_RST        = 14'h1555;
  localparam logic [2:0]  CONFIG_RST       = 3'h0;
  localparam logic [7:0]  SELECT_RST       = 8'h00;
  // groups 1..3 run from the second reference
  localparam logic [31:0] SECOND_REF_MAP   = 32'hffff_ff00;

  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_CALC} mdrb_state_t;

endpackage

// ### hw/mdrb_calibrator.sv
/*
  Shared gain/offset multiply-add for one channel at a time.
  Assumes the caller registers the result; purely combinational.
*/
`timescale 1ns/1ps
module mdrb_calibrator #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] i_code,
  input  wire logic [W-1:0] i_gain,
  input  wire logic [W-1:0] i_trim,
  output logic      [W-1:0] o_result
);
  logic        [W:0]     gain_p1;
  logic        [2*W:0]   prod;
  logic signed [W+2:0]   sum;

  assign gain_p1 = {1'b0, i_gain} + {{W{1'b0}}, 1'b1};
  assign prod    = {{(W+1){1'b0}}, i_code} * {{W{1'b0}}, gain_p1};
  // code*(gain+1)/2^W + trim - half scale
  assign sum     = $signed({2'b00, prod[2*W:W]}) + $signed({3'b000, i_trim})
                 - $signed({4'b0001, {(W-1){1'b0}}});
  // out-of-range codes saturate rather than wrap
  assign o_result = sum[W+2] ? '0 : (|sum[W+1:W]) ? '1 : sum[W-1:0];
endmodule // mdrb_calibrator

// ### hw/mdrb_register_bank.sv
/*
  Register bank of a 32-channel converter: input, gain, trim, calibrated and
  final registers, level-shift, configuration and source-select registers.
  Assumes an Avalon-MM master with waitrequest on i_clock, and a load strobe
  synchronous to the same clock.
*/
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module mdrb_register_bank
  import mdrb_pkg::*;
#(
  parameter int DATA_W = mdrb_pkg::WIDE_W
) (
  input  wire logic                                   i_clock,
  input  wire logic                                   i_rst_n,
  input  wire logic [mdrb_pkg::ADDR_W-1:0]            i_address,
  input  wire logic                                   i_read,
  input  wire logic                                   i_write,
  input  wire logic [3:0]                             i_byteenable,
  input  wire logic [31:0]                            i_writedata,
  output logic      [31:0]                            o_readdata,
  output logic                                        o_waitrequest,
  input  wire logic                                   i_load_strobe_n,
  output logic      [mdrb_pkg::CHANNELS*DATA_W-1:0]   o_final_code,
  output logic      [mdrb_pkg::CHANNELS-1:0]          o_second_reference_sel,
  output logic      [mdrb_pkg::SHIFT_W-1:0]           o_group0_level_shift,
  output logic      [mdrb_pkg::SHIFT_W-1:0]           o_upper_groups_level_shift,
  output logic                                        o_thermal_enable,
  output logic                                        o_power_down
);
  import mdrb_pkg::*;

  localparam logic [DATA_W-1:0] INPUT_RST = (DATA_W == WIDE_W) ? DATA_W'(WIDE_INPUT_RST) : DATA_W'(NARROW_INPUT_RST);
  localparam logic [DATA_W-1:0] GAIN_RST  = (DATA_W == WIDE_W) ? DATA_W'(WIDE_GAIN_RST) : DATA_W'(NARROW_GAIN_RST);
  localparam logic [DATA_W-1:0] TRIM_RST  = (DATA_W == WIDE_W) ? DATA_W'(WIDE_TRIM_RST) : DATA_W'(NARROW_TRIM_RST);

  mdrb_state_t                       state_reg;
  mdrb_state_t                       state_next;
  logic        [DATA_W-1:0]          input_a_reg [CHANNELS];
  logic        [DATA_W-1:0]          input_b_reg [CHANNELS];
  logic        [DATA_W-1:0]          gain_reg    [CHANNELS];
  logic        [DATA_W-1:0]          trim_reg    [CHANNELS];
  logic        [DATA_W-1:0]          cal_a_reg   [CHANNELS];
  logic        [DATA_W-1:0]          cal_b_reg   [CHANNELS];
  logic        [CHANNELS*DATA_W-1:0] final_reg;
  logic        [SHIFT_W-1:0]         shift0_reg;
  logic        [SHIFT_W-1:0]         shift1_reg;
  logic        [CONFIG_W-1:0]        config_reg;
  logic        [CHANNELS-1:0]        select_reg;
  logic        [CHANNELS-1:0]        second_ref_reg;
  logic        [31:0]                readdata_reg;
  logic                              waitrequest_reg;
  logic        [4:0]                 pend_chan_reg;
  logic                              pend_b_reg;

  logic        [1:0]                 addr_kind;
  logic        [4:0]                 addr_idx;
  logic                              input_sel;
  logic                              req;
  logic                              do_write;
  logic                              wr_data;
  logic                              wr_gain;
  logic                              wr_trim;
  logic                              wr_global;
  logic                              recalc_hit;
  logic        [31:0]                be_mask;
  logic        [31:0]                rd_word;
  logic        [31:0]                wr_word;
  logic        [1:0]                 sel_group;
  logic        [DATA_W-1:0]          cal_code;
  logic        [DATA_W-1:0]          cal_result;

  // decode
  assign addr_kind  = i_address[KIND_LSB +: 2];
  assign addr_idx   = i_address[CHAN_LSB +: 5];
  assign input_sel  = config_reg[CFG_INPUT_SEL_BIT];
  assign req        = i_read | i_write;
  assign do_write   = (state_reg == ST_ACK) & i_write;
  assign wr_data    = do_write & (addr_kind == KIND_DATA);
  assign wr_gain    = do_write & (addr_kind == KIND_GAIN);
  assign wr_trim    = do_write & (addr_kind == KIND_TRIM);
  assign wr_global  = do_write & (addr_kind == KIND_GLOBAL);
  assign recalc_hit = wr_data | wr_gain | wr_trim;
  assign be_mask    = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}}, {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  // partial writes keep the unselected lanes of the current value
  assign wr_word    = (rd_word & ~be_mask) | (i_writedata & be_mask);
  assign sel_group  = 2'(addr_idx - IDX_SELECT0);

  // calibrated and final registers never appear in the read map
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (addr_kind == KIND_DATA)
      rd_word[DATA_W-1:0] = input_sel ? input_b_reg[addr_idx] : input_a_reg[addr_idx];
    else if (addr_kind == KIND_GAIN)
      rd_word[DATA_W-1:0] = gain_reg[addr_idx];
    else if (addr_kind == KIND_TRIM)
      rd_word[DATA_W-1:0] = trim_reg[addr_idx];
    else if (addr_idx == IDX_SHIFT0)
      rd_word[SHIFT_W-1:0] = shift0_reg;
    else if (addr_idx == IDX_SHIFT1)
      rd_word[SHIFT_W-1:0] = shift1_reg;
    else if (addr_idx == IDX_CONFIG)
      rd_word[CONFIG_W-1:0] = config_reg;
    else if (addr_idx >= IDX_SELECT0 && addr_idx <= IDX_SELECT3)
      rd_word[SELECT_W-1:0] = select_reg[sel_group*SELECT_W +: SELECT_W];
  end

  // one shared multiply-add serves every channel, one recompute per data, gain or trim write
  assign cal_code = pend_b_reg ? input_b_reg[pend_chan_reg] : input_a_reg[pend_chan_reg];

  mdrb_calibrator #(
    .W (DATA_W)
  ) u_calibrator (
    .i_code   (cal_code),
    .i_gain   (gain_reg[pend_chan_reg]),
    .i_trim   (trim_reg[pend_chan_reg]),
    .o_result (cal_result)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (req) state_next = ST_ACK;
      ST_ACK:  state_next = recalc_hit ? ST_CALC : ST_IDLE;
      ST_CALC: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_reg       <= ST_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg    <= 32'h0000_0000;
      pend_chan_reg   <= 5'h00;
      pend_b_reg      <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      waitrequest_reg <= (state_next != ST_ACK);
      if (state_reg == ST_IDLE && i_read)
        readdata_reg <= rd_word;
      if (recalc_hit)
      begin
        pend_chan_reg <= addr_idx;
        pend_b_reg    <= input_sel;
      end
    end
  end

  // per-channel storage
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        input_a_reg[c] <= INPUT_RST;
        input_b_reg[c] <= INPUT_RST;
        gain_reg[c]    <= GAIN_RST;
        trim_reg[c]    <= TRIM_RST;
      end
    end
    else
    begin
      if (wr_data && !input_sel)
        input_a_reg[addr_idx] <= wr_word[DATA_W-1:0];
      if (wr_data && input_sel)
        input_b_reg[addr_idx] <= wr_word[DATA_W-1:0];
      if (wr_gain)
        gain_reg[addr_idx] <= wr_word[DATA_W-1:0];
      if (wr_trim)
        trim_reg[addr_idx] <= wr_word[DATA_W-1:0];
    end
  end

  // calibrated registers: reset to the untrimmed default result
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        cal_a_reg[c] <= INPUT_RST;
        cal_b_reg[c] <= INPUT_RST;
      end
    end
    else if (state_reg == ST_CALC)
    begin
      if (pend_b_reg)
        cal_b_reg[pend_chan_reg] <= cal_result;
      else
        cal_a_reg[pend_chan_reg] <= cal_result;
    end
  end

  // strobe held low makes the finals track every recompute
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      final_reg <= {CHANNELS{INPUT_RST}};
    else if (!i_load_strobe_n)
    begin
      for (int c = 0; c < CHANNELS; c++)
        final_reg[c*DATA_W +: DATA_W] <= select_reg[c] ? cal_b_reg[c] : cal_a_reg[c];
    end
  end

  // global registers
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      shift0_reg     <= SHIFT_RST;
      shift1_reg     <= SHIFT_RST;
      config_reg     <= CONFIG_RST;
      select_reg     <= {GROUPS{SELECT_RST}};
      second_ref_reg <= SECOND_REF_MAP;
    end
    else if (wr_global)
    begin
      if (addr_idx == IDX_SHIFT0)
        shift0_reg <= wr_word[SHIFT_W-1:0];
      else if (addr_idx == IDX_SHIFT1)
        shift1_reg <= wr_word[SHIFT_W-1:0];
      else if (addr_idx == IDX_CONFIG)
        config_reg <= wr_word[CONFIG_W-1:0];
      else if (addr_idx >= IDX_SELECT0 && addr_idx <= IDX_SELECT3)
        select_reg[sel_group*SELECT_W +: SELECT_W] <= wr_word[SELECT_W-1:0];
      else if (addr_idx == IDX_SELECT_ALL)
        select_reg <= {CHANNELS{i_writedata[0]}};
    end
  end

  assign o_readdata                 = readdata_reg;
  assign o_waitrequest              = waitrequest_reg;
  assign o_final_code               = final_reg;
  assign o_second_reference_sel     = second_ref_reg;
  assign o_group0_level_shift       = shift0_reg;
  assign o_upper_groups_level_shift = shift1_reg;
  assign o_thermal_enable           = config_reg[CFG_THERMAL_BIT];
  assign o_power_down               = config_reg[CFG_POWER_DOWN_BIT];

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_input_a_write: assert property (wr_data && !input_sel |=>
    input_a_reg[$past(addr_idx)] == $past(wr_word[DATA_W-1:0]))
    else $error("input A not written");
  a_input_b_steer: assert property (wr_data && input_sel |=>
    input_b_reg[$past(addr_idx)] == $past(wr_word[DATA_W-1:0])
    && input_a_reg[$past(addr_idx)] == $past(input_a_reg[addr_idx]))
    else $error("selector did not steer to input B");
  a_gain_write: assert property (wr_gain |=> gain_reg[$past(addr_idx)] == $past(wr_word[DATA_W-1:0]))
    else $error("gain not written");
  a_recalc_follows: assert property (recalc_hit |=>
    state_reg == ST_CALC && o_waitrequest ##1 state_reg == ST_IDLE)
    else $error("recompute not scheduled after write");
  a_cal_result: assert property (state_reg == ST_CALC && !pend_b_reg |=>
    cal_a_reg[$past(pend_chan_reg)] == $past(cal_result))
    else $error("calibrated A not loaded");
  a_final_load: assert property (!i_load_strobe_n |=>
    final_reg[DATA_W-1:0] == $past(select_reg[0] ? cal_b_reg[0] : cal_a_reg[0]))
    else $error("final register 0 not loaded under strobe");
  a_final_hold: assert property (i_load_strobe_n |=> $stable(o_final_code))
    else $error("final registers moved without strobe");
  a_select_all: assert property (wr_global && addr_idx == IDX_SELECT_ALL |=>
    select_reg == {CHANNELS{$past(i_writedata[0])}})
    else $error("select-all command not applied");
  a_select_group: assert property (wr_global && addr_idx == IDX_SELECT0 |=>
    select_reg[SELECT_W-1:0] == $past(wr_word[SELECT_W-1:0]))
    else $error("group 0 select not written");
  a_config_bits: assert property (wr_global && addr_idx == IDX_CONFIG |=>
    o_power_down == $past(wr_word[0]) && o_thermal_enable == $past(wr_word[1]))
    else $error("config outputs do not follow write");
  a_shift_write: assert property (wr_global && addr_idx == IDX_SHIFT1 |=>
    o_upper_groups_level_shift == $past(wr_word[SHIFT_W-1:0]))
    else $error("upper level shift not written");
  a_group_ref: assert property (o_second_reference_sel == SECOND_REF_MAP)
    else $error("reference grouping wrong");
  // reset itself is the antecedent, so the default disable must not mask it
  a_reset_values: assert property (@(posedge i_clock) disable iff (1'b0) !i_rst_n |=>
    gain_reg[0] == GAIN_RST && trim_reg[31] == TRIM_RST
    && o_group0_level_shift == SHIFT_RST && select_reg == '0 && config_reg == '0)
    else $error("reset defaults wrong");

  c_data_write: cover property (wr_data ##1 state_reg == ST_CALC);
  c_b_recalc: cover property (state_reg == ST_CALC && pend_b_reg);
  c_strobe_low: cover property (!i_load_strobe_n [*3]);
  c_select_all: cover property (wr_global && addr_idx == IDX_SELECT_ALL && i_writedata[0]);
endmodule // mdrb_register_bank

// ### tb/mdrb_host.sv
/*
  Host model: Avalon-MM master issuing single reads and writes.
  Assumes the slave answers every request by dropping waitrequest.
*/
`timescale 1ns/1ps
module mdrb_host (
  input  wire logic        i_clock,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  output logic      [9:0]  o_address,
  output logic             o_read,
  output logic             o_write,
  output logic      [3:0]  o_byteenable,
  output logic      [31:0] o_writedata
);
  initial
  begin
    o_address    = 10'h155;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_byteenable = 4'hf;
    o_writedata  = 32'h0000_0000;
  end

  // idle lines carry inverted junk so the slave cannot lean on stale values
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    o_address   <= a;
    o_writedata <= d;
    o_read      <= !wr;
    o_write     <= wr;
    @(posedge i_clock);
    while (i_waitrequest)
      @(posedge i_clock);
    q = i_readdata;
    o_read      <= 1'b0;
    o_write     <= 1'b0;
    o_address   <= ~a;
    o_writedata <= ~d;
  endtask
endmodule // mdrb_host

// ### tb/mdrb_register_bank_bench.sv
/*
  Self-checking bench for the register bank: reference model in integers.
  Assumes the wide variant and a 50 MHz clock.
*/
`timescale 1ns/1ps
module mdrb_register_bank_bench;
  import mdrb_pkg::*;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic         load_strobe_n = 1'b1;
  logic [9:0]   address;
  logic         read;
  logic         write;
  logic [3:0]   byteenable;
  logic [31:0]  writedata;
  logic [31:0]  readdata;
  logic         waitrequest;
  logic [511:0] final_code;
  logic [31:0]  second_ref;
  logic [13:0]  shift0;
  logic [13:0]  shift1;
  logic         thermal;
  logic         power_down;
  int           in_a[32], in_b[32], gain_m[32], trim_m[32], cal_a[32], cal_b[32], fin_m[32];
  logic [13:0]  sh0, sh1;
  logic [2:0]   cfg;
  logic [31:0]  sel_m;
  logic [9:0]   a;
  int           n_mismatch = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  always #10 clock = ~clock;

  mdrb_register_bank #(.DATA_W(WIDE_W)) dut (.i_clock(clock), .i_rst_n(rst_n), .i_address(address),
    .i_read(read), .i_write(write), .i_byteenable(byteenable), .i_writedata(writedata),
    .o_readdata(readdata), .o_waitrequest(waitrequest), .i_load_strobe_n(load_strobe_n),
    .o_final_code(final_code), .o_second_reference_sel(second_ref), .o_group0_level_shift(shift0),
    .o_upper_groups_level_shift(shift1), .o_thermal_enable(thermal), .o_power_down(power_down));

  mdrb_host host (.i_clock(clock), .i_waitrequest(waitrequest), .i_readdata(readdata), .o_address(address),
    .o_read(read), .o_write(write), .o_byteenable(byteenable), .o_writedata(writedata));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // saturating multiply-add; clipping keeps the code inside the converter span
  function automatic int calc(int x, int m, int c);
    longint r;
    r = (longint'(x) * (m + 1)) / 65536 + c - 32768;
    return (r < 0) ? 0 : (r > 65535) ? 65535 : int'(r);
  endfunction

  task automatic sync_fin();
    for (int c = 0; c < 32; c++)
      fin_m[c] = sel_m[c] ? cal_b[c] : cal_a[c];
  endtask

  task automatic bwr(input logic [9:0] ad, input logic [31:0] d);
    logic [31:0] q;
    int i;
    i = ad[6:2];
    host.xfer(1'b1, ad, d, q);
    case (ad[9:8])
      2'h0: if (cfg[2]) in_b[i] = d[15:0]; else in_a[i] = d[15:0];
      2'h1: gain_m[i] = d[15:0];
      2'h2: trim_m[i] = d[15:0];
      default:
        if (i == 0) sh0 = d[13:0];
        else if (i == 1) sh1 = d[13:0];
        else if (i == 2) cfg = d[2:0];
        else if (i < 7) sel_m[(i-3)*8 +: 8] = d[7:0];
        else if (i == 7) sel_m = {32{d[0]}};
    endcase
    if (ad[9:8] != 2'h3 && cfg[2]) cal_b[i] = calc(in_b[i], gain_m[i], trim_m[i]);
    if (ad[9:8] != 2'h3 && !cfg[2]) cal_a[i] = calc(in_a[i], gain_m[i], trim_m[i]);
    repeat (3) @(posedge clock);
    if (load_strobe_n == 1'b0)
      sync_fin();
  endtask

  task automatic brd(input logic [9:0] ad);
    logic [31:0] q, e;
    int i;
    i = ad[6:2];
    host.xfer(1'b0, ad, 32'h0000_0000, q);
    case (ad[9:8])
      2'h0: e = 32'(cfg[2] ? in_b[i] : in_a[i]);
      2'h1: e = 32'(gain_m[i]);
      2'h2: e = 32'(trim_m[i]);
      default: e = (i == 0) ? 32'(sh0) : (i == 1) ? 32'(sh1) : (i == 2) ? 32'(cfg) :
                   (i > 2 && i < 7) ? 32'(sel_m[(i-3)*8 +: 8]) : 32'h0000_0000;
    endcase
    chk_rd(q, e);
  endtask

  task automatic check_outs();
    for (int c = 0; c < 32; c++)
      chk_out(32'(final_code[c*16 +: 16]), 32'(fin_m[c]));
    chk_out(second_ref, 32'hffff_ff00);
    chk_out(32'(shift0), 32'(sh0));
    chk_out(32'(shift1), 32'(sh1));
    chk_out({30'h0, thermal, power_down}, 32'(cfg[1:0]));
  endtask

  initial
  begin
    void'($urandom(31));
    for (int c = 0; c < 32; c++)
    begin
      in_a[c] = 'h5554;
      in_b[c] = 'h5554;
      gain_m[c] = 'hffff;
      trim_m[c] = 'h8000;
      cal_a[c] = 'h5554;
      cal_b[c] = 'h5554;
      fin_m[c] = 'h5554;
    end
    sh0 = 14'h1555;
    sh1 = 14'h1555;
    cfg = 3'h0;
    sel_m = 32'h0000_0000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    load_strobe_n <= 1'b0;
    for (int k = 0; k < 8; k++)
      brd(10'h300 + 10'(4 * k));
    brd(10'h07c);
    brd(10'h17c);
    brd(10'h200);
    check_outs();
    $display("test reset done");
    for (int n = 0; n < 48; n++)
    begin
      a = {2'(n % 3), 1'b0, 5'($urandom), 2'h0};
      bwr(a, $urandom);
      brd(a);
      if (n % 2 == 0) bwr(10'h300 + 10'(4 * ((n / 2) % 8)), $urandom);
      if (n % 2 == 0) brd(10'h300 + 10'(4 * ((n / 2) % 8)));
      check_outs();
    end
    $display("test random done");
    bwr(10'h308, 32'h0000_0004);
    bwr(10'h114, 32'h0000_ffff);
    bwr(10'h214, 32'h0000_ffff);
    bwr(10'h014, 32'h0000_ffff);
    brd(10'h014);
    check_outs();
    bwr(10'h214, 32'h0000_0000);
    bwr(10'h014, 32'h0000_0000);
    check_outs();
    bwr(10'h31c, 32'h0000_0001);
    check_outs();
    bwr(10'h31c, 32'h0000_0000);
    check_outs();
    $display("test limits done");
    load_strobe_n <= 1'b1;
    bwr(10'h31c, 32'h0000_0001);
    bwr(10'h00c, 32'h0000_1234);
    check_outs();
    load_strobe_n <= 1'b0;
    repeat (2) @(posedge clock);
    sync_fin();
    check_outs();
    $display("test strobe done");
    bwr(10'h320, 32'hffff_ffff);
    brd(10'h320);
    brd(10'h37c);
    check_outs();
    $display("test unmapped done");
    close_out();
  end
endmodule // mdrb_register_bank_bench
